// ==== hdl/asr_host.sv ====
// Purpose: host controller driving a 32K x 8 asynchronous static memory
// Assumes: one 20 MHz clock, user requests synchronous to it
// Notes:   one access at a time; every pin output comes from a flip-flop
//
// Notes on behaviour
// R01: memory holds 32K bytes, addressed by 15 lines over shared 8-bit data pins.
// R02: select high deselects the memory; its data pins float, standby power.
// R03: read data valid within 12 ns of stable address, select, output drive low.
// R04: after an address change old read data holds at least 3 ns.
// R05: output drive high keeps the memory's data pins floating.
// R06: a write happens only while select and write strobe are both low.
// R07: data setup and hold count from whichever strobe rises first.
// R08: select rising with write strobe keeps memory outputs floating.
// R09: write strobe stays high through every read.
// R10: in strobe-controlled writes output drive stays high throughout; the code holds it low when WR_KEEP_OE_IN is high.
// R11: never drive write data while the memory may still drive the pins.
// R12: write with output drive low lasts float delay plus data setup.
// R13: select and write strobe low float memory pins regardless of output drive.
`timescale 1ns/100ps
module asr_host (
    input  wire logic                       REF_CLK_IN,
    input  wire logic                       RESETN_IN,
    input  wire logic                       REQ_VALID_IN,
    input  wire asr_pkg::asr_req_t          REQ_IN,
    input  wire logic                       WR_KEEP_OE_IN,
    output logic                            REQ_READY_OUT,
    output logic [asr_pkg::DATA_W-1:0]      RDATA_OUT,
    output logic                            RDATA_VALID_OUT,
    output logic                            WDONE_OUT,
    output logic [asr_pkg::ADDR_W-1:0]      MEM_ADDR_OUT,
    output logic                            MEM_SEL_N_OUT,
    output logic                            MEM_OUT_DRIVE_N_OUT,
    output logic                            MEM_WR_STROBE_N_OUT,
    input  wire logic [asr_pkg::DATA_W-1:0] SHARED_DATA_PINS_IN,
    output logic [asr_pkg::DATA_W-1:0]      SHARED_DATA_PINS_OUT,
    output logic                            SHARED_DATA_PINS_OE_OUT
);
    import asr_pkg::*;

    asr_state_t        state_reg;
    asr_state_t        state_next;
    logic              keep_oe_reg;
    logic              keep_oe_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic              sel_n_reg;
    logic              sel_n_next;
    logic              oe_n_reg;
    logic              oe_n_next;
    logic              we_n_reg;
    logic              we_n_next;
    logic              doe_reg;
    logic              doe_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic              wdone_reg;
    logic              wdone_next;
    logic              ready_reg;
    logic              ready_next;
    logic              cnt_load;
    logic [CNT_W-1:0]  cnt_val;
    logic              cnt_done;

    wire accept    = (state_reg == ST_IDLE) && REQ_VALID_IN;
    wire acc_read  = accept && !REQ_IN.write;
    wire acc_write = accept && REQ_IN.write;

    asr_delay u_delay (
        .clk_in      (REF_CLK_IN),
        .rst_n_in    (RESETN_IN),
        .load_in     (cnt_load),
        .load_val_in (cnt_val),
        .done_out    (cnt_done)
    );

    always_comb begin
        state_next   = state_reg;
        keep_oe_next = keep_oe_reg;
        addr_next    = addr_reg;
        wdata_next   = wdata_reg;
        sel_n_next   = sel_n_reg;
        oe_n_next    = oe_n_reg;
        we_n_next    = we_n_reg;
        doe_next     = doe_reg;
        rdata_next   = rdata_reg;
        rvalid_next  = 1'b0;
        wdone_next   = 1'b0;
        cnt_load     = 1'b0;
        cnt_val      = CNT_ZERO;
        unique case (state_reg)
            ST_IDLE: begin
                doe_next = 1'b0;
                if (acc_read) begin
                    // address, select and output drive go together [R01] [R03]
                    addr_next  = REQ_IN.addr;
                    sel_n_next = 1'b0;
                    oe_n_next  = 1'b0;
                    we_n_next  = 1'b1;            // [R09]
                    cnt_load   = 1'b1;
                    cnt_val    = AA_LOAD;
                    state_next = ST_READ;
                end else if (acc_write) begin
                    addr_next    = REQ_IN.addr;
                    wdata_next   = REQ_IN.wdata;
                    keep_oe_next = WR_KEEP_OE_IN;
                    sel_n_next   = 1'b0;          // [R06]
                    we_n_next    = 1'b0;          // [R06]
                    oe_n_next    = !WR_KEEP_OE_IN; // [R10]
                    if (WR_KEEP_OE_IN) begin
                        // memory may still drive until the strobe floats it [R11] [R13]
                        doe_next   = 1'b0;
                        cnt_load   = 1'b1;
                        cnt_val    = HZWE_LOAD;
                        state_next = ST_W_FLOAT;
                    end else begin
                        // output drive high, pins already floating [R05] [R11]
                        doe_next   = 1'b1;
                        cnt_load   = 1'b1;
                        cnt_val    = SD_LOAD;
                        state_next = ST_W_SETUP;
                    end
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    // sampled a whole period after the address, well past access time [R03]
                    rdata_next  = SHARED_DATA_PINS_IN;
                    rvalid_next = 1'b1;
                    // address held until after the sample, old data hold not relied on [R04]
                    sel_n_next  = 1'b1;           // [R02]
                    oe_n_next   = 1'b1;           // [R05]
                    cnt_load    = 1'b1;
                    cnt_val     = HZOE_LOAD;
                    state_next  = ST_RD_TURN;
                end
            end
            ST_RD_TURN: begin
                // give the memory time to float before any write may drive [R11]
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_W_FLOAT: begin
                if (cnt_done) begin
                    // float delay has passed; setup time now starts [R12]
                    doe_next   = 1'b1;
                    cnt_load   = 1'b1;
                    cnt_val    = SD_LOAD;
                    state_next = ST_W_SETUP;
                end
            end
            ST_W_SETUP: begin
                if (cnt_done) begin
                    // both strobes rise on one edge, write ends here [R07] [R08]
                    sel_n_next = 1'b1;
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    state_next = ST_W_END;
                end
            end
            ST_W_END: begin
                // data and address held one cycle past the rising strobes [R07]
                doe_next   = 1'b0;
                wdone_next = 1'b1;
                state_next = keep_oe_reg ? ST_RD_TURN : ST_IDLE;
                if (keep_oe_reg) begin
                    cnt_load = 1'b1;
                    cnt_val  = HZOE_LOAD;
                end
            end
            default: begin
                sel_n_next = 1'b1;
                oe_n_next  = 1'b1;
                we_n_next  = 1'b1;
                doe_next   = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
    end

    assign ready_next = (state_next == ST_IDLE);

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_reg   <= ST_IDLE;
            keep_oe_reg <= 1'b0;
            addr_reg    <= ADDR_RST;
            wdata_reg   <= DATA_RST;
            sel_n_reg   <= 1'b1;
            oe_n_reg    <= 1'b1;
            we_n_reg    <= 1'b1;
            doe_reg     <= 1'b0;
            rdata_reg   <= DATA_RST;
            rvalid_reg  <= 1'b0;
            wdone_reg   <= 1'b0;
            ready_reg   <= 1'b1;
        end else begin
            state_reg   <= state_next;
            keep_oe_reg <= keep_oe_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            sel_n_reg   <= sel_n_next;
            oe_n_reg    <= oe_n_next;
            we_n_reg    <= we_n_next;
            doe_reg     <= doe_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= rvalid_next;
            wdone_reg   <= wdone_next;
            ready_reg   <= ready_next;
        end
    end

    assign REQ_READY_OUT           = ready_reg;
    assign RDATA_OUT               = rdata_reg;
    assign RDATA_VALID_OUT         = rvalid_reg;
    assign WDONE_OUT               = wdone_reg;
    assign MEM_ADDR_OUT            = addr_reg;
    assign MEM_SEL_N_OUT           = sel_n_reg;
    assign MEM_OUT_DRIVE_N_OUT     = oe_n_reg;
    assign MEM_WR_STROBE_N_OUT     = we_n_reg;
    assign SHARED_DATA_PINS_OUT    = wdata_reg;
    assign SHARED_DATA_PINS_OE_OUT = doe_reg;
endmodule

// ==== hdl/asr_pkg.sv ====
// Purpose: shared constants and types for the static memory host controller
// Assumes: 20 MHz controller clock, memory with 12 ns class timing
// Notes:   cycle counts derive from the nanosecond figures and the clock period
package asr_pkg;

    localparam int ADDR_W   = 15;
    localparam int DATA_W   = 8;
    localparam int WORDS    = 32768;
    localparam int CNT_W    = 4;

    localparam int CLK_PERIOD_NS = 50;

    // least times the controller must wait or hold, rounded up to whole cycles
    localparam int T_AA_NS   = 12;
    localparam int T_HZOE_NS = 5;
    localparam int T_HZWE_NS = 7;
    localparam int T_SD_NS   = 8;
    localparam int T_PWE_NS  = 8;

    localparam int AA_CYC_RAW    = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZOE_CYC_RAW  = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZWE_CYC_RAW  = (T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SD_PWE_NS     = (T_SD_NS > T_PWE_NS) ? T_SD_NS : T_PWE_NS;
    localparam int SD_CYC_RAW    = (SD_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int AA_CYC   = (AA_CYC_RAW < 1) ? 1 : AA_CYC_RAW;
    localparam int HZOE_CYC = (HZOE_CYC_RAW < 1) ? 1 : HZOE_CYC_RAW;
    localparam int HZWE_CYC = (HZWE_CYC_RAW < 1) ? 1 : HZWE_CYC_RAW;
    localparam int SD_CYC   = (SD_CYC_RAW < 1) ? 1 : SD_CYC_RAW;

    // counter load values: a load of n gives n+1 cycles in the waiting state
    localparam logic [CNT_W-1:0] AA_LOAD   = CNT_W'(AA_CYC - 1);
    localparam logic [CNT_W-1:0] HZOE_LOAD = CNT_W'(HZOE_CYC - 1);
    localparam logic [CNT_W-1:0] HZWE_LOAD = CNT_W'(HZWE_CYC - 1);
    localparam logic [CNT_W-1:0] SD_LOAD   = CNT_W'(SD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

    // pin levels after reset: deselected, strobes high, address zero
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_READ    = 3'b001,
        ST_RD_TURN = 3'b010,
        ST_W_FLOAT = 3'b011,
        ST_W_SETUP = 3'b100,
        ST_W_END   = 3'b101
    } asr_state_t;

endpackage

// ==== hdl/asr_delay.sv ====
// Purpose: down counter that times waits between memory pin edges
// Assumes: load value counted in controller clock cycles
// Notes:   done is high while the count stands at zero
`timescale 1ns/100ps
module asr_delay (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      load_in,
    input  wire logic [asr_pkg::CNT_W-1:0] load_val_in,
    output logic                           done_out
);
    import asr_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    assign cnt_next = load_in ? load_val_in :
                      (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - 4'h1;
    assign done_out = (cnt_reg == CNT_ZERO);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ==== verif/asr_host_assertions.sv ====
// Purpose: pin timing checks for the memory host controller
// Assumes: bound to asr_host, one clock domain
// Notes:   cycle counts follow the 20 MHz walk
`timescale 1ns/100ps
module asr_host_assertions (
    input wire logic                       REF_CLK_IN,
    input wire logic                       RESETN_IN,
    input wire logic                       REQ_VALID_IN,
    input wire asr_pkg::asr_req_t          REQ_IN,
    input wire logic                       WR_KEEP_OE_IN,
    input wire logic                       REQ_READY_OUT,
    input wire logic [asr_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic                       RDATA_VALID_OUT,
    input wire logic                       WDONE_OUT,
    input wire logic [asr_pkg::ADDR_W-1:0] MEM_ADDR_OUT,
    input wire logic                       MEM_SEL_N_OUT,
    input wire logic                       MEM_OUT_DRIVE_N_OUT,
    input wire logic                       MEM_WR_STROBE_N_OUT,
    input wire logic [asr_pkg::DATA_W-1:0] SHARED_DATA_PINS_IN,
    input wire logic [asr_pkg::DATA_W-1:0] SHARED_DATA_PINS_OUT,
    input wire logic                       SHARED_DATA_PINS_OE_OUT
);
    import asr_pkg::*;
    wire logic take = REQ_VALID_IN && REQ_READY_OUT;
    wire logic rd   = take && !REQ_IN.write;
    wire logic wr0  = take && REQ_IN.write && !WR_KEEP_OE_IN;
    wire logic wr1  = take && REQ_IN.write && WR_KEEP_OE_IN;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    a_read_answer: assert property (rd |-> ##2 RDATA_VALID_OUT && RDATA_OUT == $past(SHARED_DATA_PINS_IN))
        else $error("read data late or wrong");
    a_read_strobe: assert property (rd |=> (MEM_WR_STROBE_N_OUT && !MEM_SEL_N_OUT) ##1 MEM_WR_STROBE_N_OUT[*2])
        else $error("write strobe low in read");
    a_write_oe_high: assert property (wr0 |=> MEM_OUT_DRIVE_N_OUT[*3])
        else $error("output drive low in write");
    a_keep_oe_long: assert property (wr1 |=> (!MEM_WR_STROBE_N_OUT)[*2] ##1 MEM_WR_STROBE_N_OUT)
        else $error("long write strobe wrong");
    a_no_bus_fight: assert property (SHARED_DATA_PINS_OE_OUT && !MEM_OUT_DRIVE_N_OUT |->
        !MEM_WR_STROBE_N_OUT && !$past(MEM_WR_STROBE_N_OUT)) else $error("host drives while memory may drive");
    a_end_together: assert property ($rose(MEM_WR_STROBE_N_OUT) |-> $rose(MEM_SEL_N_OUT))
        else $error("select and strobe not raised together");
    a_data_hold: assert property ($rose(MEM_WR_STROBE_N_OUT) |-> SHARED_DATA_PINS_OE_OUT &&
        $stable(SHARED_DATA_PINS_OUT) && $stable(MEM_ADDR_OUT)) else $error("write data not held");
    a_data_setup: assert property ($rose(MEM_WR_STROBE_N_OUT) |-> $past(SHARED_DATA_PINS_OE_OUT))
        else $error("write data setup short");
    a_write_done: assert property (wr0 |-> ##3 WDONE_OUT ##1 !WDONE_OUT)
        else $error("write done pulse wrong");
    a_idle_release: assert property (REQ_READY_OUT |-> MEM_SEL_N_OUT && !SHARED_DATA_PINS_OE_OUT)
        else $error("pins not released when idle");
    c_read: cover property (rd);
    c_write: cover property (wr0);
    c_write_long: cover property (wr1);
endmodule

// ==== verif/asr_sram_model.sv ====
// Purpose: behavioural 32K x 8 asynchronous static memory
// Assumes: no pull on the data pins
// Notes:   floating pins show changing junk, never the last word
`timescale 1ns/100ps
module asr_sram_model (
    input  wire logic [asr_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                       sel_n_in,
    input  wire logic                       oe_n_in,
    input  wire logic                       we_n_in,
    input  wire logic [asr_pkg::DATA_W-1:0] din_in,
    output logic [asr_pkg::DATA_W-1:0]      dq_out,
    output logic                            drive_out
);
    import asr_pkg::*;
    logic [DATA_W-1:0] mem_reg [WORDS];
    logic              armed_reg;
    // strobe low floats pins whatever output drive does
    assign drive_out = !sel_n_in && !oe_n_in && we_n_in;
    initial begin
        dq_out = 8'h5A;
        armed_reg = 1'b0;
    end
    // store when the select/strobe overlap ends
    always @(sel_n_in or we_n_in) begin
        if (!sel_n_in && !we_n_in) begin
            armed_reg = 1'b1;
        end else if (armed_reg) begin
            mem_reg[addr_in] = din_in;
            armed_reg = 1'b0;
        end
    end
    // slowest legal part: old word 3 ns, junk, word at 12 ns
    always @(addr_in or drive_out) begin
        dq_out <= #3 ~dq_out;
        dq_out <= #12 drive_out ? mem_reg[addr_in] : ~dq_out;
    end
endmodule

// ==== verif/asr_host_bench.sv ====
// Purpose: self-checking bench for the memory host controller
// Assumes: memory model on the far side
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module asr_host_bench;
    import asr_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    logic              keep_oe = 1'b0;
    asr_req_t          req = '0;
    int                num_errors = 0;
    int                check_count = 0;
    wire logic         ready, rvalid, wdone, sel_n, oe_n, we_n, doe, mdrive;
    wire logic [7:0]   rdata, hdq, mdq, pins;
    wire logic [14:0]  addr;
    assign pins = doe ? hdq : mdq;
    always #25 clk = ~clk;
    asr_host dut_u (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .WR_KEEP_OE_IN(keep_oe), .REQ_READY_OUT(ready), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid),
        .WDONE_OUT(wdone), .MEM_ADDR_OUT(addr), .MEM_SEL_N_OUT(sel_n), .MEM_OUT_DRIVE_N_OUT(oe_n),
        .MEM_WR_STROBE_N_OUT(we_n), .SHARED_DATA_PINS_IN(pins), .SHARED_DATA_PINS_OUT(hdq),
        .SHARED_DATA_PINS_OE_OUT(doe));
    asr_sram_model mem_u (.addr_in(addr), .sel_n_in(sel_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .din_in(hdq), .dq_out(mdq), .drive_out(mdrive));
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic issue(input logic w, input logic [14:0] a, input logic [7:0] d, input logic k);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        check(ready === 1'b1, "never ready");
        req_valid = 1'b1;
        req = '{w, a, d};
        keep_oe = k;
        step();
        req_valid = 1'b0;
    endtask
    task automatic do_read(input logic [14:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        issue(1'b0, a, 8'h00, 1'b0);
        while (rvalid !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        check(rdata === exp, "read data");
        check(n == 1, "read latency");
    endtask
    task automatic do_write(input logic [14:0] a, input logic [7:0] d, input logic k);
        int n;
        n = 0;
        issue(1'b1, a, d, k);
        while (wdone !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        check(n == (k ? 3 : 2), "write latency");
    endtask
    // both parties on the bus at once
    always @(negedge clk) if (rst_n) check(!(doe === 1'b1 && mdrive === 1'b1), "bus fight");
    task automatic t_reset();
        check(sel_n === 1'b1 && oe_n === 1'b1 && we_n === 1'b1 && doe === 1'b0 && ready === 1'b1, "idle");
    endtask
    task automatic t_table();
        logic [14:0] at [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
        logic [7:0]  dt [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++) do_write(at[i], dt[i], i[0]);
        for (int i = 3; i >= 0; i--) do_read(at[i], dt[i]);
    endtask
    task automatic t_b2b();
        do_write(15'h1234, 8'h96, 1'b0);
        do_read(15'h1234, 8'h96);
        do_write(15'h1234, 8'h69, 1'b1);
        do_read(15'h1234, 8'h69);
        do_read(15'h0000, 8'hA5);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_table();
        t_b2b();
        summarize();
    end
    // whole run is about 50 cycles
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule
bind asr_host asr_host_assertions chk_u (.*);
